/* common/pfd_pkg.sv */
// Shared constants and types for the pixel fault diagnostics block
package pfd_pkg;

  localparam int NUM_SW = 8;

  // Register byte offsets
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_SWSTATE = 8'h08;
  localparam logic [7:0] ADDR_FAULT   = 8'h0C;
  localparam logic [7:0] ADDR_COUNTER = 8'h10;

  // Sticky status flag positions
  localparam int ST_TW    = 0;
  localparam int ST_TSD   = 1;
  localparam int ST_SFE   = 2;
  localparam int ST_DERR  = 3;
  localparam int ST_DWARN = 4;
  localparam int ST_WRAP  = 5;
  localparam int ST_CAP   = 6;
  localparam int ST_OV    = 7;
  localparam int ST_POR   = 8;
  localparam int ST_GND   = 9;
  localparam int NUM_ST   = 13;
  // Live bits appended above the flags in the status word
  localparam int ST_GSE   = 13;
  localparam int ST_TCMP  = 14;

  // Status after reset: only the power-on flag
  localparam logic [12:0] STAT_RST = 13'h0100;

  // Control field positions and reset value
  localparam int CT_SWEN = 0;
  localparam int CT_THR  = 1;
  localparam int CT_GNDE = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Serial frame length and counter limits
  localparam logic [5:0] FRAME_BITS = 6'h20;
  localparam logic [5:0] BITS_SAT   = 6'h3F;
  localparam logic [9:0] CNT_MAX    = 10'h3FF;

  // Per-switch fault codes
  localparam logic [2:0] CODE_OFF   = 3'h0;
  localparam logic [2:0] CODE_SHORT = 3'h1;
  localparam logic [2:0] CODE_OPEN  = 3'h2;
  localparam logic [2:0] CODE_ON    = 3'h7;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Asynchronous inputs from the analogue side and the serial pins
  typedef struct packed {
    logic              temp_warn;
    logic              temp_shdn;
    logic              temp_cmp;
    logic              cap_fail;
    logic [3:0]        str_ov;
    logic [3:0]        gnd_loss;
    logic              sclk;
    logic              chip_select_n;
    logic [NUM_SW-1:0] sw_short;
    logic [NUM_SW-1:0] sw_open;
    logic [NUM_SW-1:0] sw_ovc;
  } pfd_pins_t;

  // Idle pin levels; chip select idles high
  localparam pfd_pins_t PIN_RST = '{chip_select_n: 1'b1, default: '0};

  // Thermal supervisor states
  typedef enum logic [1:0] {
    TH_RUN  = 2'b01,
    TH_HOLD = 2'b10
  } pfd_therm_t;

endpackage

/* src/pfd_top.sv */
// Fault and diagnostic supervisor with an AXI4-Lite register slave
`timescale 1ns/1ps
module pfd_top (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     awvalid,
  output      logic                     awready,
  input  wire logic [7:0]               awaddr,
  input  wire logic                     wvalid,
  output      logic                     wready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  output      logic                     bvalid,
  input  wire logic                     bready,
  output      logic [1:0]               bresp,
  input  wire logic                     arvalid,
  output      logic                     arready,
  input  wire logic [7:0]               araddr,
  output      logic                     rvalid,
  input  wire logic                     rready,
  output      logic [31:0]              rdata,
  output      logic [1:0]               rresp,
  input  wire pfd_pkg::pfd_pins_t       pins,
  input  wire logic                     crc_fail,
  input  wire logic                     dim_on_overlap,
  input  wire logic                     dim_off_overlap,
  input  wire logic [pfd_pkg::NUM_SW-1:0] sw_request,
  output      logic [pfd_pkg::NUM_SW-1:0] switch_on_state,
  output      logic [2:0]               temp_threshold_sel,
  output      logic                     resp_global_err,
  output      logic                     pattern_stop,
  output      logic                     dim_settings_clear,
  output      logic [9:0]               dimming_counter,
  output      logic                     fault_o,
  output      logic                     fault_oe
);

  localparam int N = pfd_pkg::NUM_SW;

  pfd_pkg::pfd_pins_t  pin_m;
  pfd_pkg::pfd_pins_t  pin_s;
  pfd_pkg::pfd_therm_t th_st;
  pfd_pkg::pfd_therm_t next_th_st;
  logic [12:0]         stat;
  logic [12:0]         next_stat;
  logic [12:0]         set_v;
  logic [12:0]         clr_v;
  logic [7:0]          ctrl;
  logic [7:0]          next_ctrl;
  logic [9:0]          next_cnt;
  logic [N-1:0]        next_sw;
  logic                sclk_d;
  logic                cs_d;
  logic [5:0]          bit_cnt;
  logic                aw_full;
  logic                w_full;
  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic [3*N-1:0]      fault_codes;
  logic [31:0]         rd_mux;
  logic                rd_hit;

  wire       sw_en      = ctrl[pfd_pkg::CT_SWEN];
  wire [3:0] gnd_en     = ctrl[pfd_pkg::CT_GNDE +: 4];
  wire       aw_take    = awvalid && awready;
  wire       w_take     = wvalid && wready;
  wire       ar_take    = arvalid && arready;
  wire       wr_fire    = aw_full && w_full && !bvalid;
  wire       ctrl_wr    = wr_fire && (aw_addr == pfd_pkg::ADDR_CTRL);
  wire       wr_hit     = (aw_addr == pfd_pkg::ADDR_CTRL)
                          || (aw_addr == pfd_pkg::ADDR_STATUS)
                          || (aw_addr == pfd_pkg::ADDR_SWSTATE)
                          || (aw_addr == pfd_pkg::ADDR_FAULT)
                          || (aw_addr == pfd_pkg::ADDR_COUNTER);
  wire       stat_rd    = ar_take && (araddr == pfd_pkg::ADDR_STATUS);

  // Serial frame framing on synchronised pins
  wire       sclk_rise  = pin_s.sclk && !sclk_d;
  wire       cs_act     = !pin_s.chip_select_n;
  wire       cs_end     = pin_s.chip_select_n && !cs_d;
  wire       frame_bad  = cs_end && (bit_cnt != pfd_pkg::FRAME_BITS);

  // Enabled ground loss events only
  wire [3:0] gnd_set    = pin_s.gnd_loss & gnd_en;
  // Overlap events count only while a pattern is running
  wire       on_ovl     = dim_on_overlap && sw_en;
  wire       off_ovl    = dim_off_overlap && sw_en;
  wire       wrap       = sw_en && (dimming_counter == pfd_pkg::CNT_MAX);

  // Global switch error from live switch faults and latched string flags
  wire       gse        = (|pin_s.sw_short) || (|pin_s.sw_open)
                          || (|pin_s.sw_ovc)
                          || (|(stat[pfd_pkg::ST_GND +: 4] & gnd_en))
                          || stat[pfd_pkg::ST_CAP]
                          || stat[pfd_pkg::ST_OV];

  // Conditions that release the fault pin and open every switch
  wire       protect    = (th_st == pfd_pkg::TH_HOLD) || gse
                          || stat[pfd_pkg::ST_DERR];

  // Events that drop the switch enable; hardware clear beats a write
  wire       hw_dis     = pin_s.temp_shdn || (|gnd_set) || (|pin_s.str_ov)
                          || on_ovl;

  // Sticky flag set vector
  assign set_v[pfd_pkg::ST_TW]    = pin_s.temp_warn;
  assign set_v[pfd_pkg::ST_TSD]   = pin_s.temp_shdn;
  assign set_v[pfd_pkg::ST_SFE]   = frame_bad || crc_fail;
  assign set_v[pfd_pkg::ST_DERR]  = on_ovl;
  assign set_v[pfd_pkg::ST_DWARN] = off_ovl;
  assign set_v[pfd_pkg::ST_WRAP]  = wrap;
  assign set_v[pfd_pkg::ST_CAP]   = pin_s.cap_fail;
  assign set_v[pfd_pkg::ST_OV]    = |pin_s.str_ov;
  assign set_v[pfd_pkg::ST_POR]   = 1'b0;
  assign set_v[pfd_pkg::ST_GND +: 4] = gnd_set;

  // A status read clears exactly what it returns; a set in that cycle wins.
  // The shutdown flag keeps setting while hot, so a read cannot drop it.
  assign clr_v     = stat_rd ? stat : '0;
  assign next_stat = (stat & ~clr_v) | set_v;

  // Thermal supervisor: leave hold only when cool and both flags clear
  always_comb
  begin
    next_th_st = th_st;
    case (th_st)
      pfd_pkg::TH_RUN:
        if (pin_s.temp_shdn)
          next_th_st = pfd_pkg::TH_HOLD;
      pfd_pkg::TH_HOLD:
        if (!pin_s.temp_warn && !stat[pfd_pkg::ST_TW]
            && !stat[pfd_pkg::ST_TSD] && !pin_s.temp_shdn)
          next_th_st = pfd_pkg::TH_RUN;
      default:
        next_th_st = pfd_pkg::TH_HOLD;
    endcase
  end

  // Control register: byte lane 0 carries every field
  always_comb
  begin
    next_ctrl = ctrl;
    if (ctrl_wr && w_strb[0])
      next_ctrl = w_data[7:0];
    if (hw_dis)
      next_ctrl[pfd_pkg::CT_SWEN] = 1'b0;
  end

  // Dimming counter runs only while enabled; disable resets it
  assign next_cnt = !sw_en ? '0 : dimming_counter + 10'h001;

  // Switch drive; any protective state or disable opens them all
  assign next_sw = (protect || !sw_en) ? '0 : sw_request;

  // Per-switch fault codes, short before open
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_code
      assign fault_codes[3*gi +: 3] =
        pin_s.sw_short[gi]     ? pfd_pkg::CODE_SHORT :
        pin_s.sw_open[gi]      ? pfd_pkg::CODE_OPEN  :
        switch_on_state[gi]    ? pfd_pkg::CODE_ON    :
                                 pfd_pkg::CODE_OFF;
    end
  endgenerate

  // Read decode
  always_comb
  begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (araddr)
      pfd_pkg::ADDR_STATUS:
      begin
        rd_mux[12:0]             = stat;
        rd_mux[pfd_pkg::ST_GSE]  = gse;
        rd_mux[pfd_pkg::ST_TCMP] = pin_s.temp_cmp;
      end
      pfd_pkg::ADDR_CTRL:    rd_mux[7:0]   = ctrl;
      pfd_pkg::ADDR_SWSTATE: rd_mux[N-1:0] = switch_on_state;
      pfd_pkg::ADDR_FAULT:   rd_mux[3*N-1:0] = fault_codes;
      pfd_pkg::ADDR_COUNTER: rd_mux[9:0]   = dimming_counter;
      default:               rd_hit = 1'b0;
    endcase
  end

  // Handshakes and fixed outputs
  assign awready            = !aw_full && !bvalid;
  assign wready             = !w_full && !bvalid;
  assign arready            = !rvalid;
  assign temp_threshold_sel = ctrl[pfd_pkg::CT_THR +: 3];
  assign pattern_stop       = stat[pfd_pkg::ST_DERR];
  assign dim_settings_clear = !sw_en;
  assign fault_o            = 1'b0;
  // Combinational so release follows the latching edge directly
  assign fault_oe           = !protect;

  // Two-stage synchroniser for all pin inputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_m <= pfd_pkg::PIN_RST;
      pin_s <= pfd_pkg::PIN_RST;
    end
    else
    begin
      pin_m <= pins;
      pin_s <= pin_m;
    end
  end

  // Frame bit counter, saturating so long frames still flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_d  <= 1'b0;
      cs_d    <= 1'b1;
      bit_cnt <= '0;
    end
    else
    begin
      sclk_d <= pin_s.sclk;
      cs_d   <= pin_s.chip_select_n;
      if (!cs_act)
        bit_cnt <= '0;
      else if (sclk_rise && bit_cnt != pfd_pkg::BITS_SAT)
        bit_cnt <= bit_cnt + 6'h01;
    end
  end

  // Flags, control, thermal state, counter and switches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat            <= pfd_pkg::STAT_RST;
      ctrl            <= pfd_pkg::CTRL_RST;
      th_st           <= pfd_pkg::TH_RUN;
      dimming_counter <= '0;
      switch_on_state <= '0;
      resp_global_err <= 1'b0;
    end
    else
    begin
      stat            <= next_stat;
      ctrl            <= next_ctrl;
      th_st           <= next_th_st;
      dimming_counter <= next_cnt;
      switch_on_state <= next_sw;
      resp_global_err <= gse;
    end
  end

  // Write channel: address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= pfd_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full <= 1'b1;
        aw_addr <= awaddr;
      end
      if (w_take)
      begin
        w_full <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_fire)
      begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_hit ? pfd_pkg::RESP_OKAY : pfd_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= pfd_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_hit ? pfd_pkg::RESP_OKAY : pfd_pkg::RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // Checks on the supervisor's behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_hot;
    th_st == pfd_pkg::TH_HOLD;
  endsequence

  sequence s_cool_gate;
    pin_s.temp_warn || stat[pfd_pkg::ST_TW] || stat[pfd_pkg::ST_TSD];
  endsequence

  por_flag_a: assert property (
    !$past(aresetn) |-> stat[pfd_pkg::ST_POR])
    else $error("power-on flag not set after reset");

  warn_set_a: assert property (
    pin_s.temp_warn |=> stat[pfd_pkg::ST_TW])
    else $error("warning flag missed");

  hold_off_a: assert property (
    s_hot ##1 s_hot |-> !fault_oe && switch_on_state == '0)
    else $error("switches or fault pin active in shutdown");

  resume_gate_a: assert property (
    s_hot and s_cool_gate |=> th_st == pfd_pkg::TH_HOLD)
    else $error("left shutdown too early");

  frame_len_a: assert property (
    frame_bad |=> stat[pfd_pkg::ST_SFE])
    else $error("frame length error missed");

  crc_err_a: assert property (
    crc_fail |=> stat[pfd_pkg::ST_SFE])
    else $error("checksum error missed");

  dim_err_a: assert property (
    on_ovl |=> stat[pfd_pkg::ST_DERR] && !fault_oe && !sw_en
               ##1 switch_on_state == '0)
    else $error("on overlap not handled");

  dim_warn_a: assert property (
    off_ovl && !hw_dis && !protect |=> stat[pfd_pkg::ST_DWARN] && sw_en)
    else $error("off overlap not handled");

  gse_fault_a: assert property (
    gse |-> !fault_oe ##1 switch_on_state == '0)
    else $error("global error did not release fault");

  gnd_dis_a: assert property (
    |gnd_set |=> !sw_en && !fault_oe)
    else $error("ground loss did not disable");

  ov_dis_a: assert property (
    |pin_s.str_ov |=> !sw_en && stat[pfd_pkg::ST_OV] ##1 resp_global_err)
    else $error("overvoltage did not disable");

  wrap_flag_a: assert property (
    wrap |=> stat[pfd_pkg::ST_WRAP] && dimming_counter == '0)
    else $error("counter wrap not flagged");

  cap_gse_a: assert property (
    pin_s.cap_fail |=> gse && !fault_oe)
    else $error("capacitor failure not raised");

  read_clear_a: assert property (
    stat_rd |=> (stat & $past(stat) & ~$past(set_v)) == '0)
    else $error("read did not clear returned flags");

  set_wins_a: assert property (
    set_v != '0 |=> (stat & $past(set_v)) == $past(set_v))
    else $error("event lost during clear");

  off_reset_a: assert property (
    !sw_en |=> dimming_counter == '0 && switch_on_state == '0)
    else $error("disable did not reset counter");

  fault_now_a: assert property (
    $rose(stat[pfd_pkg::ST_DERR]) |-> !fault_oe)
    else $error("fault release late");

endmodule // pfd_top

/* test/pfd_host_model.sv */
// Behavioural host serial master sending frames of a chosen bit count
`timescale 1ns/1ps
module pfd_host_model (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [5:0] nbits,
  output      logic       sclk,
  output      logic       chip_select_n,
  output      logic       busy
);
  // Serial clock stands still between frames; half bits last 2 cycles
  // so the 2-FF synchroniser inside the block never misses an edge
  initial
  begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    busy = 1'b0;
    forever
    begin
      @(posedge aclk);
      while (!go)
        @(posedge aclk);
      busy <= 1'b1;
      chip_select_n <= 1'b0;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < nbits; i++)
      begin
        sclk <= 1'b1;
        repeat (2) @(posedge aclk);
        sclk <= 1'b0;
        repeat (2) @(posedge aclk);
      end
      chip_select_n <= 1'b1;
      repeat (2) @(posedge aclk);
      busy <= 1'b0;
    end
  end
endmodule // pfd_host_model

/* test/tb_top.sv */
// Self-checking bench for the pixel fault diagnostics block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, go, h_sclk, h_csn;
  logic        h_busy, crc_fail, on_ovl, off_ovl, gerr, pstop, dclr;
  logic        fault_o, fault_oe;
  logic [7:0]  awaddr, araddr, sw_req, sw_on;
  logic [31:0] wdata, rdata, st;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  thr;
  logic [5:0]  nbits;
  logic [9:0]  dcnt;
  int          n_fail = 0;
  int          check_count = 0;
  int          cycles = 0;
  pfd_pkg::pfd_pins_t pins, pins_in;

  // Serial pins come from the host model, the rest from the scenarios
  always_comb
  begin
    pins_in = pins;
    pins_in.sclk = h_sclk;
    pins_in.chip_select_n = h_csn;
  end

  pfd_top u_pfd_top (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .pins(pins_in),
    .crc_fail(crc_fail), .dim_on_overlap(on_ovl), .dim_off_overlap(off_ovl),
    .sw_request(sw_req), .switch_on_state(sw_on), .temp_threshold_sel(thr),
    .resp_global_err(gerr), .pattern_stop(pstop),
    .dim_settings_clear(dclr), .dimming_counter(dcnt),
    .fault_o(fault_o), .fault_oe(fault_oe)
  );

  pfd_host_model u_pfd_host_model (
    .aclk(aclk), .go(go), .nbits(nbits), .sclk(h_sclk),
    .chip_select_n(h_csn), .busy(h_busy)
  );

  // 50 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Watchdog: the whole run needs far fewer cycles than this
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      test_done;
    end
  end

  // Bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
        @(posedge aclk);
        if (bvalid)
        begin
          resp = bresp;
          bready <= 1'b0;
          break;
        end
        if (awvalid && awready)
          awvalid <= 1'b0;
        if (wvalid && wready)
          wvalid <= 1'b0;
      end
    end
  endtask

  // Bus read; data and response taken at the edge rvalid is seen
  task automatic rd(input logic [7:0] a);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
        @(posedge aclk);
        if (rvalid)
        begin
          st = rdata;
          resp = rresp;
          rready <= 1'b0;
          break;
        end
        if (arvalid && arready)
          arvalid <= 1'b0;
      end
    end
  endtask

  // Reset, power-on flag, read clear and unmapped accesses
  task automatic t_reset;
    begin
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(pfd_pkg::ADDR_STATUS);
      `CHK(st, 32'h0000_0100)
      rd(pfd_pkg::ADDR_STATUS);
      `CHK(st, 32'h0000_0000)
      rd(pfd_pkg::ADDR_CTRL);
      `CHK({resp, st[7:0]}, {pfd_pkg::RESP_OKAY, pfd_pkg::CTRL_RST})
      rd(8'h14);
      `CHK({resp, st}, {pfd_pkg::RESP_SLVERR, 32'h0})
      wr(8'h14, 32'hFFFF_FFFF);
      `CHK(resp, pfd_pkg::RESP_SLVERR)
    end
  endtask

  // Warning only latches; shutdown holds until read with condition gone
  task automatic t_thermal;
    begin
      sw_req <= 8'h5A;
      wr(pfd_pkg::ADDR_CTRL, 32'h0000_0001);
      pins.temp_warn <= 1'b1;
      repeat (4) @(posedge aclk);
      pins.temp_warn <= 1'b0;
      repeat (4) @(posedge aclk);
      `CHK(sw_on, 8'h5A)
      sw_req <= 8'hFF;
      rd(pfd_pkg::ADDR_STATUS);
      `CHK(st[pfd_pkg::ST_TW], 1'b1)
      pins.temp_shdn <= 1'b1;
      repeat (5) @(posedge aclk);
      `CHK({fault_o, fault_oe, sw_on}, 10'h000)
      rd(pfd_pkg::ADDR_STATUS);
      pins.temp_shdn <= 1'b0;
      repeat (4) @(posedge aclk);
      `CHK(fault_oe, 1'b0)
      rd(pfd_pkg::ADDR_STATUS);
      `CHK(st[pfd_pkg::ST_TSD], 1'b1)
      repeat (3) @(posedge aclk);
      `CHK(fault_oe, 1'b1)
    end
  endtask

  // Every threshold code, then the live comparator bit
  task automatic t_tempcmp;
    begin
      for (int i = 0; i < 8; i++)
      begin
        wr(pfd_pkg::ADDR_CTRL, 32'(i) << 1);
        `CHK({resp, thr}, {pfd_pkg::RESP_OKAY, 3'(i)})
      end
      pins.temp_cmp <= 1'b1;
      repeat (4) @(posedge aclk);
      rd(pfd_pkg::ADDR_STATUS);
      `CHK(st[pfd_pkg::ST_TCMP], 1'b1)
      pins.temp_cmp <= 1'b0;
    end
  endtask

  // Frames of 32, 31 and 33 bits, then a checksum failure
  task automatic t_frame;
    logic [5:0] len [3];
    begin
      len = '{6'h20, 6'h1F, 6'h21};
      for (int i = 0; i < 3; i++)
      begin
        nbits <= len[i];
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        @(posedge aclk);
        while (h_busy)
          @(posedge aclk);
        repeat (4) @(posedge aclk);
        rd(pfd_pkg::ADDR_STATUS);
        `CHK(st[pfd_pkg::ST_SFE], len[i] != 6'h20)
      end
      crc_fail <= 1'b1;
      @(posedge aclk);
      crc_fail <= 1'b0;
      rd(pfd_pkg::ADDR_STATUS);
      `CHK(st[pfd_pkg::ST_SFE], 1'b1)
    end
  endtask

  // Off overlap only warns; the on overlap then stops the pattern until read
  task automatic t_dimming;
    begin
      wr(pfd_pkg::ADDR_CTRL, 32'h0000_0001);
      off_ovl <= 1'b1;
      @(posedge aclk);
      off_ovl <= 1'b0;
      repeat (4) @(posedge aclk);
      `CHK({fault_oe, sw_on}, 9'h1FF)
      on_ovl <= 1'b1;
      @(posedge aclk);
      on_ovl <= 1'b0;
      repeat (4) @(posedge aclk);
      `CHK({pstop, fault_oe, sw_on}, 10'h200)
      rd(pfd_pkg::ADDR_STATUS);
      `CHK(st[4:3], 2'h3)
      `CHK(pstop, 1'b0)
    end
  endtask

  // Disabled ground check, then capacitor, overvoltage, ground and switch short/open faults in turn
  task automatic t_faults;
    int pos [4];
    begin
      pos = '{pfd_pkg::ST_CAP, pfd_pkg::ST_OV, pfd_pkg::ST_GND,
              pfd_pkg::ST_GSE};
      wr(pfd_pkg::ADDR_CTRL, 32'h0000_0001);
      pins.gnd_loss[1] <= 1'b1;
      repeat (5) @(posedge aclk);
      rd(pfd_pkg::ADDR_STATUS);
      `CHK({fault_oe, st[pfd_pkg::ST_GND+1]}, 2'h2)
      pins.gnd_loss[1] <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        wr(pfd_pkg::ADDR_CTRL, 32'h0000_0011);
        repeat (4) @(posedge aclk);
        case (i)
          0: pins.cap_fail <= 1'b1;
          1: pins.str_ov[0] <= 1'b1;
          2: pins.gnd_loss[0] <= 1'b1;
          default:
          begin
            pins.sw_short[0] <= 1'b1;
            pins.sw_open[1] <= 1'b1;
          end
        endcase
        repeat (5) @(posedge aclk);
        `CHK({gerr, fault_oe, sw_on}, 10'h200)
        rd(pfd_pkg::ADDR_FAULT);
        `CHK(st[2:0] == pfd_pkg::CODE_SHORT, i == 3)
        `CHK(st[5:3], i == 3 ? pfd_pkg::CODE_OPEN : pfd_pkg::CODE_OFF)
        rd(pfd_pkg::ADDR_CTRL);
        `CHK(st[0], i == 0 || i == 3)
        pins <= pfd_pkg::PIN_RST;
        repeat (4) @(posedge aclk);
        rd(pfd_pkg::ADDR_STATUS);
        `CHK(st[pos[i]], i != 3)
        rd(pfd_pkg::ADDR_STATUS);
        `CHK(st[pos[i]], 1'b0)
      end
    end
  endtask

  // Counter wrap flag, then disable clears counter and dimming settings
  task automatic t_wrap;
    begin
      wr(pfd_pkg::ADDR_CTRL, 32'h0000_0001);
      rd(pfd_pkg::ADDR_STATUS);
      repeat (2100) @(posedge aclk);
      rd(pfd_pkg::ADDR_STATUS);
      `CHK(st[pfd_pkg::ST_WRAP], 1'b1)
      wr(pfd_pkg::ADDR_CTRL, 32'h0000_0000);
      repeat (2) @(posedge aclk);
      `CHK({dclr, dcnt, sw_on}, 19'h40000)
    end
  endtask

  // Verdict and end of run
  task automatic test_done;
    begin
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // Main sequence; a second reset at the end re-checks the power-on flag
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {go, crc_fail, on_ovl, off_ovl} = 4'h0;
    {awaddr, araddr, wdata, nbits} = 54'h0;
    sw_req = 8'hFF;
    pins = pfd_pkg::PIN_RST;
    t_reset;
    t_thermal;
    t_tempcmp;
    t_frame;
    t_dimming;
    t_faults;
    t_wrap;
    t_reset;
    test_done;
  end
endmodule // tb_top
